// ===== core/rsg_guard.sv
// region and subregion guard: register access and access checking
`timescale 1ns/100ps
`default_nettype none
module rsg_guard
    import rsg_pkg::*;
#(
    parameter int unsigned N = RSG_REGIONS
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic reg_valid,
    input wire logic reg_write,
    input wire logic [3:0] reg_addr,
    input wire logic [1:0] reg_size,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    output logic reg_ack,
    output logic reg_err,
    input wire logic chk_valid,
    input wire logic [31:0] chk_addr,
    input wire logic chk_write,
    input wire logic chk_priv,
    output logic chk_grant,
    output logic chk_fault,
    input wire logic [1:0] status_clr,
    output logic [1:0] memfault_status,
    output logic [31:0] fault_addr
);
    localparam int unsigned IW = (N > 1) ? $clog2(N) : 1;

    typedef struct packed {
        logic [IW-1:0] number;
        logic [N-1:0][31:0] base;
        logic [N-1:0][31:0] attr;
        logic [31:0] rdata;
        logic ack;
        logic err;
        logic grant;
        logic fault;
        logic [1:0] status;
        logic [31:0] faddr;
    } rsg_state_t;

    rsg_state_t st_q, st_d;
    logic [N-1:0] hit;
    logic any_hit;
    logic [IW-1:0] win_idx;
    logic allow;
    logic sel_num, sel_base, sel_attr;
    logic legal;
    logic [3:0] lanes;

    // access permission decode for the winning region
    function automatic logic perm_ok(input logic [2:0] ap,
                                     input logic priv,
                                     input logic wr);
        case (ap)
            3'h1: perm_ok = priv;
            3'h2: perm_ok = priv || !wr;
            3'h3: perm_ok = 1'b1;
            3'h5: perm_ok = priv && !wr;
            3'h6, 3'h7: perm_ok = !wr;
            default: perm_ok = 1'b0; // no access, reserved code faults too
        endcase
    endfunction : perm_ok

    // byte lanes touched by a sized access
    function automatic logic [3:0] lane_mask(input logic [1:0] sz,
                                             input logic [1:0] off);
        case (sz)
            RSG_SZ_BYTE: lane_mask = 4'h1 << off;
            RSG_SZ_HALF: lane_mask = off[1] ? 4'hc : 4'h3;
            RSG_SZ_WORD: lane_mask = 4'hf;
            default: lane_mask = 4'h0;
        endcase
    endfunction : lane_mask

    // one matcher per region
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_region
            rsg_region_match u_match (
                .clk(clk),
                .rst_n(rst_n),
                .base(st_q.base[g]),
                .attr(st_q.attr[g]),
                .addr(chk_addr),
                .hit(hit[g])
            );
        end
    endgenerate

    // highest numbered hit wins, so a smaller region placed above a
    // larger one takes over where the larger one has subregions off
    always_comb begin
        any_hit = 1'b0;
        win_idx = '0;
        for (int i = 0; i < N; i++) begin
            if (hit[i]) begin
                any_hit = 1'b1;
                win_idx = IW'(i);
            end
        end
    end
    // only the permission field steers the outcome, never c/b/s/tex
    assign allow = perm_ok(st_q.attr[win_idx][RSG_AP_LSB +: 3],
                           chk_priv, chk_write);

    // register decode; only the attribute register takes narrow access
    assign sel_num = reg_addr[3:2] == RSG_OFF_NUMBER[3:2];
    assign sel_base = reg_addr[3:2] == RSG_OFF_BASE[3:2];
    assign sel_attr = reg_addr[3:2] == RSG_OFF_ATTR[3:2];
    assign lanes = lane_mask(reg_size, reg_addr[1:0]);
    assign legal = sel_attr
        ? (lanes != 4'h0) && !(reg_size == RSG_SZ_HALF && reg_addr[0])
          && !(reg_size == RSG_SZ_WORD && reg_addr[1:0] != 2'h0)
        : (sel_num || sel_base) && reg_size == RSG_SZ_WORD
          && reg_addr[1:0] == 2'h0;

    // next state: register port, checker result and sticky status
    always_comb begin
        st_d = st_q;
        st_d.ack = 1'b0;
        st_d.err = 1'b0;
        st_d.grant = 1'b0;
        st_d.fault = 1'b0;
        if (reg_valid) begin
            st_d.ack = legal;
            st_d.err = !legal;
            if (legal && reg_write) begin
                if (sel_num) begin
                    st_d.number = reg_wdata[IW-1:0];
                end else if (sel_base) begin
                    st_d.base[st_q.number] = reg_wdata & RSG_BASE_MASK;
                end else begin
                    // narrow writes merge into their lanes; attributes are
                    // kept under RSG_ATTR_MASK so software reads back the writable bits unchanged
                    for (int b = 0; b < 4; b++) begin
                        if (lanes[b]) begin
                            st_d.attr[st_q.number][8*b +: 8] =
                                reg_wdata[8*b +: 8] & RSG_ATTR_MASK[8*b +: 8];
                        end
                    end
                end
            end
            if (legal && !reg_write) begin
                if (sel_num) begin
                    st_d.rdata = 32'(st_q.number);
                end else if (sel_base) begin
                    st_d.rdata = st_q.base[st_q.number];
                end else begin
                    st_d.rdata = st_q.attr[st_q.number];
                end
            end
        end
        // clear first so a fault in the same cycle wins over the clear
        st_d.status = st_q.status & ~status_clr;
        if (chk_valid) begin
            if (!any_hit) begin
                st_d.fault = 1'b1;
                st_d.status[RSG_ST_MISS] = 1'b1;
                st_d.faddr = chk_addr;
            end else if (!allow) begin
                st_d.fault = 1'b1;
                st_d.status[RSG_ST_PERM] = 1'b1;
                st_d.faddr = chk_addr;
            end else begin
                st_d.grant = 1'b1;
            end
        end
    end

    // single state register; ce low freezes everything
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_q <= '{number: '0, base: {N{RSG_BASE_RST}},
                      attr: {N{RSG_ATTR_RST}}, rdata: 32'h0000_0000,
                      ack: 1'b0, err: 1'b0, grant: 1'b0, fault: 1'b0,
                      status: 2'h0, faddr: 32'h0000_0000};
        end else if (ce) begin
            st_q <= st_d;
        end
    end

    assign reg_rdata = st_q.rdata;
    assign reg_ack = st_q.ack;
    assign reg_err = st_q.err;
    assign chk_grant = st_q.grant;
    assign chk_fault = st_q.fault;
    assign memfault_status = st_q.status;
    assign fault_addr = st_q.faddr;

    AST_MISS_FAULT: assert property (@(posedge clk)
        disable iff (!rst_n)
        ce && chk_valid && !any_hit |=> chk_fault && !chk_grant
        && memfault_status[RSG_ST_MISS] && fault_addr == $past(chk_addr))
        else $error("uncovered access did not fault");
    AST_PERM_FAULT: assert property (@(posedge clk)
        disable iff (!rst_n)
        ce && chk_valid && any_hit && !allow |=> chk_fault
        && memfault_status[RSG_ST_PERM])
        else $error("permission violation not recorded");
    AST_OVERLAP_GRANT: assert property (@(posedge clk)
        disable iff (!rst_n)
        ce && chk_valid && any_hit && allow |=> chk_grant && !chk_fault)
        else $error("covered permitted access refused");
    AST_WORD_ONLY: assert property (@(posedge clk)
        disable iff (!rst_n)
        ce && reg_valid && !sel_attr && reg_size != RSG_SZ_WORD
        |=> reg_err && !reg_ack)
        else $error("narrow access to word-only register accepted");
    AST_UNALIGNED: assert property (@(posedge clk)
        disable iff (!rst_n)
        ce && reg_valid && reg_write && reg_size == RSG_SZ_WORD
        && reg_addr[1:0] != 2'h0 |=> reg_err && $stable(st_q.attr)
        && $stable(st_q.base))
        else $error("unaligned register write changed state");
    AST_ATTR_KEEP: assert property (@(posedge clk)
        disable iff (!rst_n)
        ce && reg_valid && reg_write && sel_attr && reg_size == RSG_SZ_WORD
        && reg_addr[1:0] == 2'h0 |=> st_q.attr[$past(st_q.number)]
        == ($past(reg_wdata) & RSG_ATTR_MASK))
        else $error("attribute word not kept for readback");
    AST_STATUS_STICKY: assert property (@(posedge clk)
        disable iff (!rst_n)
        ce && chk_fault && !chk_valid && status_clr == 2'h0 ##1 ce
        && !chk_valid && status_clr == 2'h0
        |=> memfault_status == $past(memfault_status, 2))
        else $error("fault status lost without a clear");

    COV_MISS: cover property (@(posedge clk) disable iff (!rst_n)
        ce && chk_valid && !any_hit);
    COV_OVERLAP: cover property (@(posedge clk) disable iff (!rst_n)
        ce && chk_valid && any_hit && win_idx != '0);
    COV_BYTE_ATTR: cover property (@(posedge clk) disable iff (!rst_n)
        ce && reg_valid && reg_write && sel_attr && reg_size == RSG_SZ_BYTE);
endmodule : rsg_guard
`default_nettype wire

// ===== core/rsg_region_match.sv
// package of shared constants and the per-region address matcher
`timescale 1ns/100ps
`default_nettype none
package rsg_pkg;
    localparam int unsigned RSG_REGIONS = 8;
    // register offsets within the guard register window
    localparam logic [3:0] RSG_OFF_NUMBER = 4'h0;
    localparam logic [3:0] RSG_OFF_BASE = 4'h4;
    localparam logic [3:0] RSG_OFF_ATTR = 4'h8;
    // access size codes from the core
    localparam logic [1:0] RSG_SZ_BYTE = 2'h0;
    localparam logic [1:0] RSG_SZ_HALF = 2'h1;
    localparam logic [1:0] RSG_SZ_WORD = 2'h2;
    // field positions inside region_attr_size_reg
    localparam int unsigned RSG_EN_BIT = 0;
    localparam int unsigned RSG_SIZE_LSB = 1;
    localparam int unsigned RSG_SRD_LSB = 8;
    localparam int unsigned RSG_B_BIT = 16;
    localparam int unsigned RSG_C_BIT = 17;
    localparam int unsigned RSG_S_BIT = 18;
    localparam int unsigned RSG_TEX_LSB = 19;
    localparam int unsigned RSG_AP_LSB = 24;
    // writable bits; everything else reads as zero
    localparam logic [31:0] RSG_ATTR_MASK = 32'h073f_ff3f;
    localparam logic [31:0] RSG_BASE_MASK = 32'hffff_ffe0;
    // reset values
    localparam logic [31:0] RSG_ATTR_RST = 32'h0000_0000;
    localparam logic [31:0] RSG_BASE_RST = 32'h0000_0000;
    // size code 7 is 256 bytes, the smallest region with subregions
    localparam logic [4:0] RSG_SUB_MIN_SIZE = 5'h07;
    localparam logic [4:0] RSG_SUB_SHIFT_ADJ = 5'h02;
    // memfault_status bit positions
    localparam int unsigned RSG_ST_PERM = 0;
    localparam int unsigned RSG_ST_MISS = 1;
endpackage : rsg_pkg

module rsg_region_match
    import rsg_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [31:0] base,
    input wire logic [31:0] attr,
    input wire logic [31:0] addr,
    output logic hit
);
    logic [4:0] size_enc;
    logic [5:0] span_log2;
    logic [31:0] span_mask;
    logic in_range;
    logic [4:0] sub_shift;
    logic [31:0] shifted;
    logic [2:0] sub_idx;
    logic [7:0] subregion_disable_mask;
    logic sub_off;

    // region covers 2^(size+1) bytes; a shift of 32 clears the mask
    assign size_enc = attr[RSG_SIZE_LSB +: 5];
    assign span_log2 = {1'b0, size_enc} + 6'h01;
    assign span_mask = 32'hffff_ffff << span_log2;
    assign in_range = (addr & span_mask) == (base & span_mask);

    // subregion is one eighth of the region, picked by offset bits
    assign sub_shift = size_enc - RSG_SUB_SHIFT_ADJ;
    assign shifted = addr >> sub_shift;
    assign sub_idx = shifted[2:0];
    assign subregion_disable_mask = attr[RSG_SRD_LSB +: 8];
    // small regions ignore the mask; software keeps it zero there
    assign sub_off = (size_enc >= RSG_SUB_MIN_SIZE) && subregion_disable_mask[sub_idx];
    assign hit = attr[RSG_EN_BIT] && in_range && !sub_off;

    AST_SUB_DISABLED: assert property (@(posedge clk)
        disable iff (!rst_n)
        attr[RSG_EN_BIT] && in_range && size_enc >= RSG_SUB_MIN_SIZE
        && subregion_disable_mask[addr[size_enc - RSG_SUB_SHIFT_ADJ +: 3]] |-> !hit)
        else $error("disabled subregion still matches");
    AST_SMALL_NO_SUB: assert property (@(posedge clk)
        disable iff (!rst_n)
        attr[RSG_EN_BIT] && in_range && size_enc < RSG_SUB_MIN_SIZE |-> hit)
        else $error("small region lost its match");
endmodule : rsg_region_match
`default_nettype wire

// ===== verif/rsg_core_model.sv
// core-side model issuing register and checked memory accesses
`timescale 1ns/100ps
`default_nettype none
module rsg_core_model (
    input wire logic clk,
    output logic reg_valid,
    output logic reg_write,
    output logic [3:0] reg_addr,
    output logic [1:0] reg_size,
    output logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata,
    input wire logic reg_ack,
    input wire logic reg_err,
    output logic chk_valid,
    output logic [31:0] chk_addr,
    output logic chk_write,
    output logic chk_priv,
    input wire logic chk_grant,
    input wire logic chk_fault
);
    // idle bus at time zero
    initial begin
        reg_valid = 1'b0;
        reg_write = 1'b0;
        reg_addr = 4'h0;
        reg_size = 2'h0;
        reg_wdata = 32'h0;
        chk_valid = 1'b0;
        chk_addr = 32'h0;
        chk_write = 1'b0;
        chk_priv = 1'b0;
    end

    // one-cycle request; released lines flip so stale data never matches
    task automatic reg_acc(input logic wr, input logic [3:0] a,
        input logic [1:0] sz, input logic [31:0] d, input int idle,
        output logic [1:0] res, output logic [31:0] rd);
        repeat (idle) @(posedge clk);
        @(posedge clk);
        reg_valid <= 1'b1;
        reg_write <= wr;
        reg_addr <= a;
        reg_size <= sz;
        reg_wdata <= d;
        @(posedge clk);
        reg_valid <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
        #1;
        res = {reg_ack, reg_err};
        rd = reg_rdata;
    endtask : reg_acc

    // checked memory access, answer sampled after the taking edge
    task automatic chk_acc(input logic [31:0] a, input logic wr,
        input logic pv, output logic [1:0] res);
        @(posedge clk);
        chk_valid <= 1'b1;
        chk_addr <= a;
        chk_write <= wr;
        chk_priv <= pv;
        @(posedge clk);
        chk_valid <= 1'b0;
        chk_addr <= ~a;
        #1;
        res = {chk_grant, chk_fault};
    endtask : chk_acc
endmodule : rsg_core_model
`default_nettype wire

// ===== verif/rsg_guard_test.sv
// self-checking testbench for the region and subregion guard
`timescale 1ns/100ps
`default_nettype none
module rsg_guard_test
    import rsg_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic [1:0] status_clr = 2'h0;
    logic reg_valid, reg_write, reg_ack, reg_err;
    logic [3:0] reg_addr;
    logic [1:0] reg_size, memfault_status, res;
    logic [31:0] reg_wdata, reg_rdata, chk_addr, fault_addr, rd;
    logic chk_valid, chk_write, chk_priv, chk_grant, chk_fault;
    int bad_count = 0;
    int checks_done = 0;
    int cycles = 0;
    localparam logic [1:0] ACK = 2'h2;
    localparam logic [1:0] ERR = 2'h1;

    always #20 clk = ~clk;

    rsg_guard dut (.clk(clk), .rst_n(rst_n), .ce(ce),
        .reg_valid(reg_valid), .reg_write(reg_write), .reg_addr(reg_addr),
        .reg_size(reg_size), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_ack(reg_ack), .reg_err(reg_err), .chk_valid(chk_valid),
        .chk_addr(chk_addr), .chk_write(chk_write), .chk_priv(chk_priv),
        .chk_grant(chk_grant), .chk_fault(chk_fault),
        .status_clr(status_clr), .memfault_status(memfault_status),
        .fault_addr(fault_addr));

    rsg_core_model core (.clk(clk), .reg_valid(reg_valid),
        .reg_write(reg_write), .reg_addr(reg_addr), .reg_size(reg_size),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
        .reg_err(reg_err), .chk_valid(chk_valid), .chk_addr(chk_addr),
        .chk_write(chk_write), .chk_priv(chk_priv),
        .chk_grant(chk_grant), .chk_fault(chk_fault));

    task automatic stop_test();
        $display("mismatches %0d, comparisons %0d", bad_count, checks_done);
        if (bad_count == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : stop_test

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp

    // register access, answer code compared
    task automatic acc(input logic w, input logic [3:0] a,
        input logic [1:0] sz, input logic [31:0] d, input logic [1:0] e);
        core.reg_acc(w, a, sz, d, 0, res, rd);
        cmp({30'h0, res}, {30'h0, e});
    endtask : acc

    // memory check, {grant, fault} compared
    task automatic chk(input logic [31:0] a, input logic w,
        input logic [1:0] e);
        core.chk_acc(a, w, 1'b0, res);
        cmp({30'h0, res}, {30'h0, e});
    endtask : chk

    // sticky status cleared by a one-cycle clear pulse
    task automatic clr();
        @(posedge clk);
        status_clr <= 2'h3;
        @(posedge clk);
        status_clr <= 2'h0;
        #1;
        cmp({30'h0, memfault_status}, 32'h0);
    endtask : clr

    task automatic t_reset();
        acc(1'b0, RSG_OFF_ATTR, RSG_SZ_WORD, 32'h0, ACK);
        cmp(rd, 32'h0);
        chk(32'h0, 1'b0, ERR);
        cmp({30'h0, memfault_status}, 32'h2);
    endtask : t_reset

    // narrow merges, refused shapes leave the register untouched
    task automatic t_regs();
        logic [3:0] ra[7] = '{4'h9, 4'hb, 4'h1, 4'h4, 4'h8, 4'hc, 4'ha};
        logic [1:0] rs[7] = '{RSG_SZ_HALF, RSG_SZ_HALF, RSG_SZ_WORD,
            RSG_SZ_BYTE, 2'h3, RSG_SZ_WORD, RSG_SZ_WORD};
        acc(1'b1, RSG_OFF_NUMBER, RSG_SZ_WORD, 32'h0, ACK);
        acc(1'b1, RSG_OFF_BASE, RSG_SZ_WORD, 32'h1f, ACK);
        acc(1'b1, RSG_OFF_ATTR, RSG_SZ_WORD, 32'h25, ACK);
        acc(1'b1, 4'h9, RSG_SZ_BYTE, 32'h300, ACK);
        acc(1'b1, 4'ha, RSG_SZ_HALF, 32'h0300_0000, ACK);
        for (int i = 0; i < 7; i++) begin
            acc(1'b1, ra[i], rs[i], 32'hffff_ffff, ERR);
        end
        acc(1'b0, RSG_OFF_ATTR, RSG_SZ_WORD, 32'h0, ACK);
        cmp(rd, 32'h0300_0325);
        acc(1'b0, RSG_OFF_BASE, RSG_SZ_WORD, 32'h0, ACK);
        cmp(rd, 32'h0);
    endtask : t_regs

    // 512KB region, lowest two 64KB subregions off
    task automatic t_sub();
        clr();
        chk(32'h0, 1'b1, ERR);
        chk(32'h1_ffff, 1'b1, ERR);
        chk(32'h2_0000, 1'b1, ACK);
        chk(32'h7_ffff, 1'b1, ACK);
        chk(32'h8_0000, 1'b1, ERR);
        cmp({30'h0, memfault_status}, 32'h2);
        cmp(fault_addr, 32'h8_0000);
    endtask : t_sub

    // 128KB read-only region fills the disabled subregions
    task automatic t_over();
        clr();
        acc(1'b1, RSG_OFF_NUMBER, RSG_SZ_WORD, 32'h1, ACK);
        acc(1'b1, RSG_OFF_BASE, RSG_SZ_WORD, 32'h0, ACK);
        acc(1'b1, RSG_OFF_ATTR, RSG_SZ_WORD, 32'h0607_0021, ACK);
        acc(1'b0, RSG_OFF_ATTR, RSG_SZ_WORD, 32'h0, ACK);
        cmp(rd, 32'h0607_0021);
        chk(32'h1_0000, 1'b0, ACK);
        chk(32'h1_fffc, 1'b1, ERR);
        cmp({30'h0, memfault_status}, 32'h1);
        chk(32'h2_0000, 1'b1, ACK);
        acc(1'b1, RSG_OFF_ATTR, RSG_SZ_BYTE, 32'h20, ACK);
        chk(32'h1_0000, 1'b0, ERR);
        cmp({30'h0, memfault_status}, 32'h3);
    endtask : t_over

    // 32-byte region has no subregions, so software keeps its mask zero
    task automatic t_small();
        acc(1'b1, RSG_OFF_NUMBER, RSG_SZ_WORD, 32'h2, ACK);
        acc(1'b1, RSG_OFF_BASE, RSG_SZ_WORD, 32'h100, ACK);
        acc(1'b1, RSG_OFF_ATTR, RSG_SZ_WORD, 32'h0300_0009, ACK);
        chk(32'h11f, 1'b1, ACK);
        chk(32'h120, 1'b1, ERR);
        cmp(fault_addr, 32'h120);
    endtask : t_small

    // ce low freezes the guard: a request is not taken, nothing recorded
    task automatic t_hold();
        clr();
        @(posedge clk);
        ce <= 1'b0;
        core.chk_acc(32'h0, 1'b0, 1'b0, res);
        cmp({30'h0, res}, 32'h0);
        cmp({30'h0, memfault_status}, 32'h0);
        cmp(fault_addr, 32'h120);
        @(posedge clk);
        ce <= 1'b1;
        chk(32'h0, 1'b0, ERR);
    endtask : t_hold

    // hang guard, far beyond the hundred or so cycles the run needs
    always @(posedge clk) begin
        cycles++;
        if (cycles > 3000) begin
            bad_count++;
            stop_test();
        end
    end

    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_regs();
        t_sub();
        t_over();
        t_small();
        t_hold();
        stop_test();
    end
endmodule : rsg_guard_test
`default_nettype wire
